// *** common/bvs_params.svh ***
`ifndef BVS_PARAMS_SVH
`define BVS_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define BVS_SCALING_IDX   8'h05
`define BVS_CEILING_IDX   8'h06
`define BVS_SCALING_ADDR  (`BVS_SCALING_IDX << 2)
`define BVS_CEILING_ADDR  (`BVS_CEILING_IDX << 2)

// Field positions of the scaling register.
`define BVS_ENABLE_BIT    7
`define BVS_LOWPWR_BIT    6
`define BVS_CODE_MSB      5
`define BVS_CODE_LSB      0

// Field positions of the ceiling register.
`define BVS_RANGE_MSB     7
`define BVS_RANGE_LSB     6

// Ceiling codes that leave the ceiling register writable.
`define BVS_CEIL_OPEN_HI  6'h3f
`define BVS_CEIL_OPEN_LO  6'h00

// Constant reset values (the byte one held until the one-time-programmable defaults load) and the write byte lane.
`define BVS_RST_BYTE      8'h00
`define BVS_RST_WORD      32'h0000_0000
`define BVS_LANE0         0

`endif

// *** common/bvs_pkg.sv ***
package bvs_pkg;

    typedef logic [7:0] bvs_byte_t;
    typedef logic [5:0] bvs_code_t;
    typedef logic [1:0] bvs_range_t;

    typedef enum logic {
        BVS_IDLE = 1'b0,
        BVS_ACK  = 1'b1
    } bvs_phase_t;

endpackage

// *** design/bvs_regs.sv ***
// Behaviour
// - Scaling bit 7 enables converter, or OTP enable bit during sequence.
// - Scaling bit 6 selects low power if allowed.
// - Scaling bits 5..0 set output voltage code.
// - Power request low restores default voltage code.
// - Ceiling bits 7..6 select the output span.
// - Codes above ceiling code are replaced by it.
// - Ceiling code (bits 5..0) other than 3f or 00 locks ceiling.
// - Both registers return to defaults on reset.
// - Source pick chooses primary or scaling code.
`timescale 1ns/1ps
`include "bvs_params.svh"

module bvs_regs (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire bvs_pkg::bvs_byte_t otpScalingDefault,
    input  wire bvs_pkg::bvs_byte_t otpCeilingDefault,
    input  wire logic              otpEnableInSequence,
    input  wire logic              powerUpSequenceActive,
    input  wire logic              powerRequestInput,
    input  wire logic              buck1OperatingSelect,
    input  wire logic              voltageSourcePick,
    input  wire bvs_pkg::bvs_code_t primaryVoltageCode,
    output logic                   buck1Enable,
    output logic                   buck1LowPower,
    output bvs_pkg::bvs_code_t     buck1VoltageCode,
    output bvs_pkg::bvs_range_t    buck1Range,
    output logic                   ceilingLocked
);
    import bvs_pkg::*;

    bvs_phase_t phase;
    bvs_phase_t next_phase;
    logic [31:0] next_readdata;
    logic        next_waitrequest;

    bvs_byte_t  scaling;
    bvs_byte_t  ceiling;
    logic       defaultsLoaded;
    bvs_byte_t  next_scaling;
    bvs_byte_t  next_ceiling;
    logic       next_defaultsLoaded;

    logic       next_enable;
    logic       next_lowPower;
    bvs_code_t  next_code;
    bvs_range_t next_range;
    logic       next_locked;

    logic      request;
    logic      accept;
    logic      lockNow;
    bvs_code_t ceilCode;
    bvs_code_t wrCode;
    bvs_code_t srcCode;

    assign request  = avs_read | avs_write;
    // A request is taken at the edge where the slave shows waitrequest low.
    assign accept   = request & (phase == BVS_ACK);
    assign ceilCode = ceiling[`BVS_CODE_MSB:`BVS_CODE_LSB];
    assign lockNow  = (ceilCode != `BVS_CEIL_OPEN_HI) && (ceilCode != `BVS_CEIL_OPEN_LO);
    assign wrCode   = avs_writedata[`BVS_CODE_MSB:`BVS_CODE_LSB];

    // Bus handshake: one wait cycle, then one cycle with waitrequest low.
    always_comb begin
        next_phase       = BVS_IDLE;
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        if (request && phase == BVS_IDLE) begin
            next_phase       = BVS_ACK;
            next_waitrequest = 1'b0;
            next_readdata    = `BVS_RST_WORD;
            if (avs_address == `BVS_SCALING_ADDR) begin
                next_readdata[7:0] = scaling;
            end else if (avs_address == `BVS_CEILING_ADDR) begin
                next_readdata[7:0] = ceiling;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase           <= BVS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `BVS_RST_WORD;
        end else begin
            phase           <= next_phase;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // Register contents. The asynchronous reset can only load constants, so the
    // programmed defaults are copied in on the first edge after release.
    always_comb begin
        next_scaling        = scaling;
        next_ceiling        = ceiling;
        next_defaultsLoaded = 1'b1;
        if (!defaultsLoaded) begin
            next_scaling = otpScalingDefault;
            next_ceiling = otpCeilingDefault;
        end else if (accept && avs_write && avs_byteenable[`BVS_LANE0]) begin
            if (avs_address == `BVS_SCALING_ADDR) begin
                next_scaling[`BVS_ENABLE_BIT] = avs_writedata[`BVS_ENABLE_BIT];
                next_scaling[`BVS_LOWPWR_BIT] = avs_writedata[`BVS_LOWPWR_BIT];
                // A code above the ceiling is stored as the ceiling itself.
                next_scaling[`BVS_CODE_MSB:`BVS_CODE_LSB] =
                    (wrCode > ceilCode) ? ceilCode : wrCode;
            end else if (avs_address == `BVS_CEILING_ADDR && !lockNow) begin
                next_ceiling = avs_writedata[7:0];
            end
        end
        // Held at default while the power request is low; this wins over writes.
        if (defaultsLoaded && !powerRequestInput) begin
            next_scaling[`BVS_CODE_MSB:`BVS_CODE_LSB] =
                otpScalingDefault[`BVS_CODE_MSB:`BVS_CODE_LSB];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scaling        <= `BVS_RST_BYTE;
            ceiling        <= `BVS_RST_BYTE;
            defaultsLoaded <= 1'b0;
        end else begin
            scaling        <= next_scaling;
            ceiling        <= next_ceiling;
            defaultsLoaded <= next_defaultsLoaded;
        end
    end

    // Converter controls, registered so every output comes from a flip-flop.
    always_comb begin
        srcCode = voltageSourcePick ? scaling[`BVS_CODE_MSB:`BVS_CODE_LSB]
                                    : primaryVoltageCode;
        next_enable   = scaling[`BVS_ENABLE_BIT] |
                        (otpEnableInSequence & powerUpSequenceActive);
        next_lowPower = scaling[`BVS_LOWPWR_BIT] & ~buck1OperatingSelect;
        // The primary code is clamped here because it is stored elsewhere.
        next_code     = (srcCode > ceilCode) ? ceilCode : srcCode;
        next_range    = ceiling[`BVS_RANGE_MSB:`BVS_RANGE_LSB];
        next_locked   = lockNow;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            buck1Enable      <= 1'b0;
            buck1LowPower    <= 1'b0;
            buck1VoltageCode <= '0;
            buck1Range       <= '0;
            ceilingLocked    <= 1'b0;
        end else begin
            buck1Enable      <= next_enable;
            buck1LowPower    <= next_lowPower;
            buck1VoltageCode <= next_code;
            buck1Range       <= next_range;
            ceilingLocked    <= next_locked;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_wait_one_cycle: assert property (
        request && avs_waitrequest && phase == BVS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");

    a_defaults_loaded: assert property (
        !defaultsLoaded |=> scaling == $past(otpScalingDefault) && ceiling == $past(otpCeilingDefault))
        else $error("defaults not taken from programmed memory");

    a_code_restored: assert property (
        defaultsLoaded && !powerRequestInput |=>
            scaling[`BVS_CODE_MSB:`BVS_CODE_LSB] ==
            $past(otpScalingDefault[`BVS_CODE_MSB:`BVS_CODE_LSB]))
        else $error("voltage code not restored while power request low");

    a_ceiling_locked: assert property (
        defaultsLoaded && lockNow |=> ceiling == $past(ceiling))
        else $error("locked ceiling register changed");

    a_code_clamped: assert property (
        ##1 buck1VoltageCode <= $past(ceilCode))
        else $error("voltage code above ceiling");

    a_source_pick: assert property (
        voltageSourcePick && primaryVoltageCode != scaling[`BVS_CODE_MSB:`BVS_CODE_LSB]
        && scaling[`BVS_CODE_MSB:`BVS_CODE_LSB] <= ceilCode |=>
            buck1VoltageCode == $past(scaling[`BVS_CODE_MSB:`BVS_CODE_LSB]))
        else $error("scaling code not selected");

    a_low_power_gate: assert property (
        buck1OperatingSelect |=> !buck1LowPower)
        else $error("low power chosen while operating select set");

    a_enable_follow: assert property (
        scaling[`BVS_ENABLE_BIT] |=> buck1Enable)
        else $error("converter not enabled with enable bit set");

    a_range_follow: assert property (
        ##1 buck1Range == $past(ceiling[`BVS_RANGE_MSB:`BVS_RANGE_LSB]))
        else $error("span output does not follow ceiling register");

    a_scaling_write: assert property (
        defaultsLoaded && powerRequestInput && accept && avs_write && avs_byteenable[`BVS_LANE0]
        && avs_address == `BVS_SCALING_ADDR && wrCode <= ceilCode |=>
            scaling[`BVS_CODE_MSB:`BVS_CODE_LSB] == $past(wrCode))
        else $error("scaling code write lost");

    a_lock_flag: assert property (
        ##1 ceilingLocked == ($past(ceilCode) != `BVS_CEIL_OPEN_HI &&
                              $past(ceilCode) != `BVS_CEIL_OPEN_LO))
        else $error("lock flag does not match ceiling code");

endmodule

// *** testbench/bvs_host.sv ***
`timescale 1ns/1ps

module bvs_host (
    input  wire logic        sys_clk,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    output logic             timedOut
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        timedOut = 1'b0;
    end

    // The request stays put until waitrequest is sampled low; a slave that never answers is cut off.
    task automatic waitAccept();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (avs_waitrequest !== 1'b0) timedOut <= 1'b1;
    endtask

    task automatic busWrite(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= addr;
        avs_writedata <= {24'h000000, data};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        waitAccept();
        avs_write <= 1'b0;
    endtask

    task automatic busRead(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        avs_address <= addr;
        avs_read <= 1'b1;
        waitAccept();
        data = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule

// *** testbench/buck_voltage_scaling_regs_tb.sv ***
`timescale 1ns/1ps
`include "bvs_params.svh"

module buck_voltage_scaling_regs_tb;
    import bvs_pkg::*;
    localparam logic [7:0] SCL = `BVS_SCALING_ADDR;
    localparam logic [7:0] CEL = `BVS_CEILING_ADDR;
    logic sys_clk, rstn, timedOut, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    bvs_byte_t otpScalingDefault, otpCeilingDefault;
    logic otpEnableInSequence, powerUpSequenceActive, powerRequestInput;
    logic buck1OperatingSelect, voltageSourcePick, buck1Enable, buck1LowPower, ceilingLocked;
    bvs_code_t primaryVoltageCode, buck1VoltageCode;
    bvs_range_t buck1Range;
    int fails = 0;
    int testsRun = 0;

    bvs_host host_u (.sys_clk(sys_clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .timedOut(timedOut));
    bvs_regs dut_u (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .otpScalingDefault(otpScalingDefault),
        .otpCeilingDefault(otpCeilingDefault), .otpEnableInSequence(otpEnableInSequence),
        .powerUpSequenceActive(powerUpSequenceActive), .powerRequestInput(powerRequestInput),
        .buck1OperatingSelect(buck1OperatingSelect), .voltageSourcePick(voltageSourcePick),
        .primaryVoltageCode(primaryVoltageCode), .buck1Enable(buck1Enable),
        .buck1LowPower(buck1LowPower), .buck1VoltageCode(buck1VoltageCode),
        .buck1Range(buck1Range), .ceilingLocked(ceilingLocked));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        logic [31:0] d;
        host_u.busRead(addr, d);
        chk("readdata", d, {24'h000000, exp});
    endtask

    // Outputs lag by one clock, so two edges pass before they are looked at.
    task automatic settle();
        repeat (2) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (timedOut === 1'b1) begin
            fails++;
            endOfTest();
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        endOfTest();
    end

    initial begin
        rstn = 1'b0;
        otpScalingDefault = 8'h20;
        otpCeilingDefault = 8'h3f;
        otpEnableInSequence = 1'b1;
        powerUpSequenceActive = 1'b0;
        powerRequestInput = 1'b1;
        buck1OperatingSelect = 1'b0;
        voltageSourcePick = 1'b1;
        primaryVoltageCode = 6'h05;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        settle();
        rdChk(SCL, 8'h20);
        rdChk(CEL, 8'h3f);
        chk("code", 32'(buck1VoltageCode), 32'h20);
        host_u.busWrite(SCL, 8'hc5, 4'h1);
        settle();
        chk("enable", 32'(buck1Enable), 32'h1);
        chk("lowpower", 32'(buck1LowPower), 32'h1);
        chk("code", 32'(buck1VoltageCode), 32'h05);
        buck1OperatingSelect <= 1'b1;
        settle();
        chk("lowpower", 32'(buck1LowPower), 32'h0);
        powerRequestInput <= 1'b0;
        settle();
        rdChk(SCL, 8'he0);
        powerRequestInput <= 1'b1;
        host_u.busWrite(SCL, 8'h2a, 4'h0);
        rdChk(SCL, 8'he0);
        rdChk(8'h40, 8'h00);
        host_u.busWrite(CEL, 8'hbf, 4'h1);
        settle();
        chk("range", 32'(buck1Range), 32'h2);
        chk("locked", 32'(ceilingLocked), 32'h0);
        host_u.busWrite(CEL, 8'h50, 4'h1);
        settle();
        chk("locked", 32'(ceilingLocked), 32'h1);
        chk("range", 32'(buck1Range), 32'h1);
        host_u.busWrite(CEL, 8'h3f, 4'h1);
        rdChk(CEL, 8'h50);
        host_u.busWrite(SCL, 8'h3a, 4'h1);
        rdChk(SCL, 8'h10);
        voltageSourcePick <= 1'b0;
        primaryVoltageCode <= 6'h2a;
        settle();
        chk("code", 32'(buck1VoltageCode), 32'h10);
        primaryVoltageCode <= 6'h05;
        powerUpSequenceActive <= 1'b1;
        settle();
        chk("code", 32'(buck1VoltageCode), 32'h05);
        chk("enable", 32'(buck1Enable), 32'h1);
        otpEnableInSequence <= 1'b0;
        settle();
        chk("enable", 32'(buck1Enable), 32'h0);
        powerUpSequenceActive <= 1'b0;
        otpEnableInSequence <= 1'b1;
        settle();
        chk("enable", 32'(buck1Enable), 32'h0);
        rstn <= 1'b0;
        otpScalingDefault <= 8'h9c;
        settle();
        rstn <= 1'b1;
        settle();
        rdChk(CEL, 8'h3f);
        rdChk(SCL, 8'h9c);
        host_u.busWrite(CEL, 8'h40, 4'h1);
        settle();
        chk("locked", 32'(ceilingLocked), 32'h0);
        chk("code", 32'(buck1VoltageCode), 32'h00);
        host_u.busWrite(CEL, 8'h3f, 4'h1);
        rdChk(CEL, 8'h3f);
        endOfTest();
    end
endmodule
